// *** src/lan_led_annunciator.sv ***
// LED annunciator logic: per-LED OR of inverted inputs, latch, colour drive, APB config
//
// Function
// [R1] Each of an LED's five inputs has its own inversion bit, off by default, applied before the OR.
// [R2] Up to five enabled inputs are ORed and a true result shows the on colour, red by default.
// [R3] A false result shows the off colour from the same five choices, dark by default.
// [R4] Each LED is non-latching, latching or latching acknowledged by alarm, latching by default.
// [R5] A plain latch clears on its acknowledge signal only while no causing input is asserted.
// [R6] The acknowledge selector is used only in plain latching mode and ignored otherwise.
// [R7] Flashing colours toggle at one fixed rate from the system clock shared by all LEDs.
//
// Implementation choices: register access over APB and the placing of the registers.
module lan_led_annunciator #(
	parameter int NUM_LEDS = 4,
	parameter int NUM_SIGNALS = 32,
	parameter int FLASH_HALF = lan_pkg::FLASH_HALF_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lan_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_SIGNALS-1:0] status_in,
	input wire logic alarm_in,
	output logic [NUM_LEDS-1:0] led_green,
	output logic [NUM_LEDS-1:0] led_red
);
	import lan_pkg::*;

	localparam int FCNT_W = $clog2(FLASH_HALF + 1);

	// Configuration storage
	logic [31:0] cfg_q [NUM_LEDS];
	logic [31:0] asn_q [NUM_LEDS];

	// Bus response
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// Per-LED state
	logic [NUM_LEDS-1:0] cond_w;
	logic [NUM_LEDS-1:0] held_q;
	logic [NUM_LEDS-1:0] green_q;
	logic [NUM_LEDS-1:0] red_q;

	// Flash divider
	logic [FCNT_W-1:0] fcnt_q;
	logic flash_tick;
	logic flash_phase_q;

	// Address decode: kind 0 unmapped, 1 state, 2 cfg, 3 asn
	function automatic logic [1:0] addr_kind(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		int idx;
		rel = a - REG_LED_BASE;
		idx = int'(rel / REG_LED_STRIDE);
		addr_kind = 2'd0;
		if (a == REG_STATE) begin
			addr_kind = 2'd1;
		end else if (a >= REG_LED_BASE && idx < NUM_LEDS) begin
			if (rel[3:0] == LED_CFG_OFS) begin
				addr_kind = 2'd2;
			end else if (rel[3:0] == LED_ASN_OFS) begin
				addr_kind = 2'd3;
			end
		end
	endfunction

	function automatic int addr_led(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - REG_LED_BASE;
		addr_led = int'(rel / REG_LED_STRIDE);
	endfunction

	// Colour code and flash phase to {red, green}
	function automatic logic [1:0] colour_drive(input logic [2:0] code, input logic phase);
		colour_drive = 2'b00;
		case (lan_colour_t'(code))
			LAN_COL_GREEN: colour_drive = 2'b01;
			LAN_COL_RED: colour_drive = 2'b10;
			LAN_COL_RED_FLASH: colour_drive = {phase, 1'b0}; // [R7]
			LAN_COL_GREEN_FLASH: colour_drive = {1'b0, phase}; // [R7]
			default: colour_drive = 2'b00;
		endcase
	endfunction

	// Signal picked by a selector field; out-of-range selectors read as low
	function automatic logic pick(input logic [NUM_SIGNALS-1:0] sig, input logic [4:0] sel);
		pick = 1'b0;
		if (int'(sel) < NUM_SIGNALS) begin
			pick = sig[sel];
		end
	endfunction

	logic access_done;
	logic [1:0] req_kind;
	int req_led;

	assign access_done = psel && penable && pready_q;
	assign req_kind = addr_kind(paddr);
	assign req_led = addr_led(paddr);

	// APB: answer prepared in setup, ready in the first access cycle
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pready_q <= 1'b1;
			// Unmapped addresses and writes to the read-only state word error out
			pslverr_q <= (req_kind == 2'd0) || (pwrite && req_kind == 2'd1);
		end else if (access_done) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (req_kind)
				2'd1: begin
					prdata_q <= 32'h0000_0000;
					prdata_q[ST_COND_LSB +: NUM_LEDS] <= cond_w;
					prdata_q[ST_HELD_LSB +: NUM_LEDS] <= held_q;
					prdata_q[ST_GREEN_LSB +: NUM_LEDS] <= green_q;
					prdata_q[ST_RED_LSB +: NUM_LEDS] <= red_q;
				end
				2'd2: prdata_q <= cfg_q[req_led];
				2'd3: prdata_q <= asn_q[req_led];
				default: prdata_q <= 32'h0000_0000;
			endcase
		end else if (access_done) begin
			prdata_q <= 32'h0000_0000;
		end
	end

	// Configuration writes take effect at the completing edge only
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_LEDS; i++) begin
				cfg_q[i] <= CFG_RESET; // [R1] [R2] [R3] [R4]
				asn_q[i] <= ASN_RESET;
			end
		end else if (access_done && pwrite) begin
			if (req_kind == 2'd2) begin
				// Unused bits read back as zero
				cfg_q[req_led] <= {{(32 - CFG_USED_W){1'b0}}, pwdata[CFG_USED_W-1:0]};
			end else if (req_kind == 2'd3) begin
				asn_q[req_led] <= {{(32 - ASN_USED_W){1'b0}}, pwdata[ASN_USED_W-1:0]};
			end
		end
	end

	// Shared flash rate for every LED
	assign flash_tick = (fcnt_q == FCNT_W'(FLASH_HALF - 1));

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			fcnt_q <= '0;
		end else if (flash_tick) begin
			fcnt_q <= '0;
		end else begin
			fcnt_q <= fcnt_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			flash_phase_q <= 1'b0;
		end else if (flash_tick) begin
			flash_phase_q <= ~flash_phase_q; // [R7]
		end
	end

	// Per-LED channel logic
	for (genvar g = 0; g < NUM_LEDS; g++) begin : g_led
		logic [NUM_INPUTS-1:0] raw;
		logic [NUM_INPUTS-1:0] inv;
		logic [NUM_INPUTS-1:0] en;
		logic [2:0] on_colour_select;
		logic [2:0] off_colour_select;
		lan_latch_t latch_mode;
		logic ack;
		logic lit;
		logic [1:0] drive;

		for (genvar k = 0; k < NUM_INPUTS; k++) begin : g_in
			assign raw[k] = pick(status_in, asn_q[g][k*SEL_FIELD_W +: SEL_FIELD_W]);
		end

		assign inv = cfg_q[g][CFG_INV_LSB +: NUM_INPUTS];
		assign en = cfg_q[g][CFG_EN_LSB +: NUM_INPUTS];
		assign on_colour_select = cfg_q[g][CFG_ON_LSB +: 3];
		assign off_colour_select = cfg_q[g][CFG_OFF_LSB +: 3];
		assign latch_mode = lan_latch_t'(cfg_q[g][CFG_LATCH_LSB +: 2]);

		// Inversion before the OR; unassigned inputs drop out
		assign cond_w[g] = |((raw ^ inv) & en); // [R1] [R2]

		// Acknowledge source follows the latch mode
		always_comb begin
			case (latch_mode)
				LAN_LATCH_ACK_SIGNAL: ack = pick(status_in, asn_q[g][ASN_ACK_LSB +: SEL_FIELD_W]); // [R6]
				LAN_LATCH_ACK_ALARM: ack = alarm_in;
				default: ack = 1'b0; // [R6]
			endcase
		end

		// Set wins: a clear is honoured only with every causing input gone
		always_ff @(posedge sys_clk) begin
			if (!resetn) begin
				held_q[g] <= 1'b0;
			end else if (latch_mode == LAN_LATCH_NONE || latch_mode > LAN_LATCH_ACK_ALARM) begin
				held_q[g] <= 1'b0; // [R4]
			end else if (cond_w[g]) begin
				held_q[g] <= 1'b1; // [R4]
			end else if (ack) begin
				held_q[g] <= 1'b0; // [R5]
			end
		end

		assign lit = cond_w[g] || held_q[g]; // [R4]
		assign drive = lit ? colour_drive(on_colour_select, flash_phase_q)
			: colour_drive(off_colour_select, flash_phase_q); // [R2] [R3]

		always_ff @(posedge sys_clk) begin
			if (!resetn) begin
				green_q[g] <= 1'b0;
				red_q[g] <= 1'b0;
			end else begin
				green_q[g] <= drive[0];
				red_q[g] <= drive[1];
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign led_green = green_q;
	assign led_red = red_q;

endmodule

// *** src/lan_pkg.sv ***
// Package: constants, register map and types of the LED annunciator logic
package lan_pkg;

	// Clock and flash timing
	localparam int CLK_FREQ_HZ = 50_000_000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLK_FREQ_HZ / 1000);

	// Per-LED structure
	localparam int NUM_INPUTS = 5;
	localparam int SEL_FIELD_W = 5;
	localparam int MAX_LEDS = 8;

	// APB register map, byte addresses
	localparam int ADDR_W = 12;
	localparam logic [11:0] REG_STATE = 12'h000;
	localparam logic [11:0] REG_LED_BASE = 12'h010;
	localparam logic [11:0] REG_LED_STRIDE = 12'h010;
	localparam logic [3:0] LED_CFG_OFS = 4'h0;
	localparam logic [3:0] LED_ASN_OFS = 4'h4;

	// LED_CFG fields
	localparam int CFG_INV_LSB = 0;
	localparam int CFG_EN_LSB = 5;
	localparam int CFG_ON_LSB = 10;
	localparam int CFG_OFF_LSB = 13;
	localparam int CFG_LATCH_LSB = 16;
	localparam int CFG_USED_W = 18;

	// LED_ASN fields: input k selector at k*SEL_FIELD_W, acknowledge selector above
	localparam int ASN_ACK_LSB = 25;
	localparam int ASN_USED_W = 30;

	// STATE fields
	localparam int ST_COND_LSB = 0;
	localparam int ST_HELD_LSB = 8;
	localparam int ST_GREEN_LSB = 16;
	localparam int ST_RED_LSB = 24;

	// Reset values: on colour red, off colour dark, latching, inputs off
	localparam logic [31:0] CFG_RESET = 32'h0001_0800;
	localparam logic [31:0] ASN_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		LAN_COL_DARK,
		LAN_COL_GREEN,
		LAN_COL_RED,
		LAN_COL_RED_FLASH,
		LAN_COL_GREEN_FLASH
	} lan_colour_t;

	typedef enum logic [1:0] {
		LAN_LATCH_NONE,
		LAN_LATCH_ACK_SIGNAL,
		LAN_LATCH_ACK_ALARM
	} lan_latch_t;

endpackage

// *** testbench/lan_led_annunciator_bench.sv ***
// Self-checking bench of the LED annunciator logic
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module lan_led_annunciator_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import lan_pkg::*;
	logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, want_alarm = 0, alarm;
	logic pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, status, want_status = 32'h0000_0000;
	logic [31:0] noise, lfsr = 32'hb55d_b10f, exp_v;
	logic [31:0] exp_q[$];
	logic [3:0] led_green, led_red;
	logic [4:0] s, a;
	int fails = 0, samples_checked = 0;
	lan_source_model lan_source_model_i (.sys_clk(sys_clk), .want_status(want_status),
		.want_alarm(want_alarm), .status_out(status), .alarm_out(alarm));
	lan_led_annunciator #(.FLASH_HALF(8)) lan_led_annunciator_i (.sys_clk(sys_clk),
		.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.status_in(status), .alarm_in(alarm), .led_green(led_green), .led_red(led_red));
	function automatic logic [31:0] cfg(logic inv, logic [2:0] on, logic [2:0] off, logic [1:0] l);
		return {14'h0, l, off, on, 4'h0, 1'b1, 4'h0, inv};
	endfunction
	// Field order red, green, held, cond for LED 0
	function automatic logic [31:0] st(logic [3:0] f);
		return {7'h0, f[3], 7'h0, f[2], 7'h0, f[1], 7'h0, f[0]};
	endfunction
	// Galois shift register step for the random levels
	function automatic logic [31:0] lfsr_next(logic [31:0] v);
		return v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
	endfunction
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		if (!wr) exp_q.push_back(d);
		psel <= 1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (!pready);
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask
	task automatic drive(input logic bs, input logic ba, input logic al);
		want_status <= noise | ({31'h0, bs} << s) | ({31'h0, ba} << a);
		want_alarm <= al;
		repeat (3) @(posedge sys_clk);
	endtask
	// Counts rising edges over 64 cycles: four periods of a 16-cycle flash
	task automatic rises(input int er, input int eg);
		int nr, ng;
		logic pr, pg;
		nr = 0;
		ng = 0;
		@(negedge sys_clk);
		repeat (64) begin
			pr = led_red[0];
			pg = led_green[0];
			@(negedge sys_clk);
			nr += (led_red[0] && !pr);
			ng += (led_green[0] && !pg);
		end
		`CHECK(nr, 4 * er)
		`CHECK(ng, 4 * eg)
		@(posedge sys_clk);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		// Only the state word refuses writes; the hole at 0x008 refuses both directions
		if (pready) begin
			`CHECK(pslverr, (paddr == 12'h008) || (pwrite && paddr == REG_STATE))
		end
		if (pready && !pwrite) begin
			exp_v = exp_q.pop_front();
			`CHECK(prdata, exp_v)
		end
	end
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		resetn <= 1;
		@(posedge sys_clk);
		apb(0, 12'h010, 32'h0001_0800);
		apb(0, 12'h014, 32'h0000_0000);
		apb(0, 12'h008, 32'h0000_0000);
		apb(1, 12'h000, 32'hffff_ffff);
		lfsr = lfsr_next(lfsr);
		s = lfsr[4:0];
		a = s ^ 5'h01;
		// Random levels on unused signals prove the selectors ignore them
		noise = {lfsr[15:0], lfsr[31:16]} & ~((32'h1 << s) | (32'h1 << a));
		apb(1, 12'h014, {2'h0, a, 20'h0, s});
		apb(1, 12'h010, cfg(1, 3'd2, 3'd1, 2'd0));
		drive(0, 0, 0);
		apb(0, 12'h000, st(4'b1001));
		drive(1, 0, 0);
		apb(0, 12'h000, st(4'b0100));
		drive(0, 0, 0);
		for (int c = 0; c < 5; c++) begin
			apb(1, 12'h010, cfg(1, c[2:0], 3'd0, 2'd0));
			rises(c == 3, c == 4);
			if (c < 3) apb(0, 12'h000, st({c == 2, c == 1, 2'b01}));
		end
		apb(1, 12'h010, cfg(0, 3'd2, 3'd0, 2'd1));
		drive(1, 0, 0);
		drive(0, 0, 0);
		apb(0, 12'h000, st(4'b1010));
		drive(1, 1, 0);
		apb(0, 12'h000, st(4'b1011));
		drive(0, 1, 0);
		apb(0, 12'h000, st(4'b0000));
		apb(1, 12'h010, cfg(0, 3'd2, 3'd0, 2'd2));
		drive(1, 0, 0);
		drive(0, 1, 0);
		apb(0, 12'h000, st(4'b1010));
		drive(0, 0, 1);
		apb(0, 12'h000, st(4'b0000));
		wrap_up();
	end
endmodule

// *** testbench/lan_led_annunciator_monitor.sv ***
// Checker of bus timing and LED drive of the annunciator
module lan_led_annunciator_monitor #(
	parameter int NUM_LEDS = 4,
	parameter int NUM_SIGNALS = 32
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lan_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_SIGNALS-1:0] status_in,
	input wire logic alarm_in,
	input wire logic [NUM_LEDS-1:0] led_green,
	input wire logic [NUM_LEDS-1:0] led_red
);
	timeunit 1ns;
	timeprecision 1ns;
	import lan_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence setup_s; psel && !penable; endsequence
	sequence access_s; psel && penable && pready; endsequence
	setup_answer_a: assert property (setup_s |=> pready) else $error("no ready after setup");
	ready_once_a: assert property (pready |=> !pready) else $error("ready held too long");
	idle_data_a: assert property (!pready |-> prdata == '0) else $error("read data not cleared");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	state_ro_a: assert property (access_s and pwrite && paddr == REG_STATE |-> pslverr)
		else $error("state write accepted");
	hole_err_a: assert property (access_s and paddr == 12'h008 |-> pslverr)
		else $error("hole accepted");
	colour_excl_a: assert property ((led_green & led_red) == '0) else $error("both colours");
	// Snapshot is taken at the setup edge, so it shows the drive of one cycle back
	state_snap_a: assert property (access_s and !pwrite && paddr == REG_STATE |->
		prdata[ST_GREEN_LSB +: NUM_LEDS] == $past(led_green)
		&& prdata[ST_RED_LSB +: NUM_LEDS] == $past(led_red)) else $error("state snapshot wrong");
endmodule
bind lan_led_annunciator lan_led_annunciator_monitor #(.NUM_LEDS(NUM_LEDS),
	.NUM_SIGNALS(NUM_SIGNALS)) lan_led_annunciator_monitor_i (.sys_clk(sys_clk),
	.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.status_in(status_in), .alarm_in(alarm_in), .led_green(led_green), .led_red(led_red));

// *** testbench/lan_source_model.sv ***
// Model of the protection functions that feed status levels and the alarm
module lan_source_model (
	input wire logic sys_clk,
	input wire logic [31:0] want_status,
	input wire logic want_alarm,
	output logic [31:0] status_out = 32'h0000_0000,
	output logic alarm_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Registered so levels change only just after an edge, as real logic would
	always_ff @(posedge sys_clk) begin
		status_out <= want_status;
		alarm_out <= want_alarm;
	end
endmodule
